// File: pkg/adf_pkg.sv
// Package: shared constants for the accelerometer filter path and its serial link
package adf_pkg;
  // Register map (device side, reached over the serial link)
  localparam logic [6:0] REG_FILTER_SETTINGS   = 7'h28;
  localparam logic [6:0] REG_SELF_TEST_CONTROL = 7'h2e;
  localparam logic [6:0] REG_ACCEL_Z_HI        = 7'h0a;
  localparam logic [6:0] REG_ACCEL_Z_MID       = 7'h0b;
  localparam logic [6:0] REG_ACCEL_Z_LO        = 7'h0c;
  localparam logic [6:0] REG_STATUS            = 7'h04;
  // Field positions
  localparam int HPF_LSB       = 4;
  localparam int HPF_MSB       = 6;
  localparam int ODR_LSB       = 0;
  localparam int ODR_MSB       = 3;
  localparam int ST_ENABLE_BIT = 0;
  localparam int ST_FORCE_BIT  = 1;
  // Reset values: highpass off, 4000 Hz output rate
  localparam logic [7:0] FILTER_RESET  = 8'h00;
  localparam logic [7:0] SELF_TEST_RESET = 8'h00;
  localparam int         ODR_MAX_CODE  = 10;
  localparam int         SAMPLE_W      = 20;
  localparam int         INTERP_FACTOR = 64;
  // Timing
  localparam int CLK_HZ            = 100_000_000;
  localparam int BASE_RATE_HZ      = 4000;
  localparam int BASE_DIV          = CLK_HZ / (BASE_RATE_HZ * INTERP_FACTOR);
  localparam int OVERRANGE_US      = 500;
  localparam int OVERRANGE_CYCLES  = OVERRANGE_US * (CLK_HZ / 1_000_000);
  localparam int LINK_DIV_HALF     = 4;
  // Overrange thresholds in milli-g
  localparam int OVR_LOW_MG        = 40_000;
  localparam int OVR_HIGH_MG       = 80_000;
  // Host controller registers (APB, word aligned)
  localparam logic [7:0] HC_CTRL   = 8'h00;
  localparam logic [7:0] HC_WDATA  = 8'h04;
  localparam logic [7:0] HC_RDATA  = 8'h08;
  localparam logic [7:0] HC_STATUS = 8'h0c;
endpackage : adf_pkg

// File: pkg/adf_link_if.sv
// Interface: SPI mode 0 link between host controller and sensor
`timescale 1ns/1ps
interface adf_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport host (output sclk, output cs_n, output mosi, input miso, input miso_oe);
  modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface : adf_link_if

// File: logic/adf_device.sv
// Device end: filter path, self test, overrange and SPI register slave
`timescale 1ns/1ps
module adf_device (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  // Link
  adf_link_if.device                link,
  // Sensor side
  input  wire logic signed [19:0]   adc_z_i,
  input  wire logic                 adc_valid_i,
  input  wire logic [1:0]           range_i,
  input  wire logic [17:0]          accel_mag_mg_i,
  // Status
  output logic                      drive_on_o,
  output logic                      st_enable_o,
  output logic                      st_force_o,
  output logic signed [19:0]        sample_o,
  output logic                      sample_valid_o,
  output logic                      interp_tick_o
);
  // Pin synchronisers
  logic [1:0] sclk_s_r, cs_s_r, mosi_s_r;
  logic       sclk_d_r;
  always_ff @(posedge core_clk_i)
  begin
    sclk_s_r <= {sclk_s_r[0], link.sclk};
    cs_s_r   <= {cs_s_r[0], link.cs_n};
    mosi_s_r <= {mosi_s_r[0], link.mosi};
    sclk_d_r <= sclk_s_r[1];
  end
  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire cs_act    = ~cs_s_r[1];
  wire mosi_bit  = mosi_s_r[1];

  // Registers
  logic [7:0]  filter_settings_r;
  logic [7:0]  self_test_control_r;
  logic [3:0]  odr_code;
  logic [2:0]  hpf_code;
  assign odr_code = filter_settings_r[adf_pkg::ODR_MSB:adf_pkg::ODR_LSB];
  assign hpf_code = filter_settings_r[adf_pkg::HPF_MSB:adf_pkg::HPF_LSB];

  // SPI framing: address byte (addr<<1 | rd), then data bytes
  logic [4:0]  bit_cnt_r;
  logic [7:0]  shift_r, tx_r;
  logic [6:0]  addr_r;
  logic        rd_r;
  logic        wr_stb;
  logic [7:0]  rd_data;
  // Only SPI framing is implemented; detection needs no setting
  assign wr_stb = cs_act & sclk_rise & (bit_cnt_r == 5'd15) & ~rd_r;
  wire addr_done = cs_act & sclk_rise & (bit_cnt_r == 5'd7);

  logic signed [19:0] out_r;
  logic               ovr_r;
  assign rd_data = (addr_r == adf_pkg::REG_FILTER_SETTINGS)   ? filter_settings_r :
                   (addr_r == adf_pkg::REG_SELF_TEST_CONTROL) ? self_test_control_r :
                   (addr_r == adf_pkg::REG_ACCEL_Z_HI)        ? out_r[19:12] :
                   (addr_r == adf_pkg::REG_ACCEL_Z_MID)       ? out_r[11:4] :
                   (addr_r == adf_pkg::REG_ACCEL_Z_LO)        ? {out_r[3:0], 4'h0} :
                   (addr_r == adf_pkg::REG_STATUS)            ? {7'h00, ovr_r} : 8'h00;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !cs_act)
    begin
      bit_cnt_r <= 5'd0;
      rd_r      <= 1'b0;
      addr_r    <= 7'h00;
      shift_r   <= 8'h00;
    end
    else if (sclk_rise)
    begin
      shift_r   <= {shift_r[6:0], mosi_bit};
      bit_cnt_r <= (bit_cnt_r == 5'd15) ? 5'd8 : bit_cnt_r + 5'd1;
      if (addr_done)
      begin
        addr_r <= shift_r[6:0];
        rd_r   <= mosi_bit;
      end
      else if (bit_cnt_r == 5'd15)
        addr_r <= addr_r + 7'd1;
    end
  end

  // Readback shifts out on falling edge for mode 0
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !cs_act)
      tx_r <= 8'h00;
    else if (sclk_rise && addr_done)
      tx_r <= 8'h00;
    else if (sclk_fall && bit_cnt_r == 5'd8)
      tx_r <= rd_data;
    else if (sclk_fall && bit_cnt_r > 5'd8)
      tx_r <= {tx_r[6:0], 1'b0};
  end
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      link.miso    <= 1'b0;
      link.miso_oe <= 1'b0;
    end
    else
    begin
      link.miso    <= (sclk_fall && bit_cnt_r == 5'd8) ? rd_data[7] : tx_r[7];
      link.miso_oe <= cs_act & rd_r;
    end
  end

  // Register writes
  wire [7:0] wdata = {shift_r[6:0], mosi_bit};
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      filter_settings_r   <= adf_pkg::FILTER_RESET;
      self_test_control_r <= adf_pkg::SELF_TEST_RESET;
    end
    else if (wr_stb)
    begin
      if (addr_r == adf_pkg::REG_FILTER_SETTINGS)
        filter_settings_r <= {1'b0, wdata[6:4],
                              (wdata[3:0] > 4'd10) ? 4'd10 : wdata[3:0]};
      if (addr_r == adf_pkg::REG_SELF_TEST_CONTROL)
        self_test_control_r <= {6'h00, wdata[1:0]};
    end
  end
  wire cfg_change = wr_stb & (addr_r == adf_pkg::REG_FILTER_SETTINGS);

  // Overrange: threshold depends on range, drive off for fixed interval
  logic [$clog2(adf_pkg::OVERRANGE_CYCLES+1)-1:0] ovr_cnt_r;
  wire [17:0] thr = (range_i == 2'd1) ? 18'(adf_pkg::OVR_LOW_MG) : 18'(adf_pkg::OVR_HIGH_MG);
  wire        ovr_hit = accel_mag_mg_i > thr;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ovr_cnt_r <= '0;
      ovr_r     <= 1'b0;
    end
    else if (!ovr_r && ovr_hit)
    begin
      ovr_r     <= 1'b1;
      ovr_cnt_r <= '0;
    end
    else if (ovr_r)
    begin
      ovr_cnt_r <= ovr_cnt_r + 1'b1;
      if (ovr_cnt_r == ($bits(ovr_cnt_r))'(adf_pkg::OVERRANGE_CYCLES - 1))
        ovr_r <= 1'b0;
    end
  end

  // Rate ticks: fine tick at 64 x 4 kHz, interpolator at 64 x output rate
  logic [8:0]  div_r;
  logic [5:0]  ip_r;
  logic [9:0]  dec_r;
  logic [9:0]  pre_r;
  wire fine_tick = (div_r == 9'(adf_pkg::BASE_DIV - 1));
  wire base_tick = fine_tick & (ip_r == 6'h3f);
  wire [9:0] dec_max = 10'((1 << odr_code) - 1);
  wire ip_tick   = fine_tick & (pre_r == dec_max);
  wire out_tick  = base_tick & (dec_r == dec_max);
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || cfg_change)
    begin
      div_r <= 9'd0;
      ip_r  <= 6'd0;
      pre_r <= 10'd0;
      dec_r <= 10'd0;
    end
    else
    begin
      div_r <= fine_tick ? 9'd0 : div_r + 9'd1;
      if (fine_tick)
      begin
        ip_r  <= ip_r + 6'd1;
        pre_r <= (pre_r == dec_max) ? 10'd0 : pre_r + 10'd1;
      end
      if (base_tick)
        dec_r <= (dec_r == dec_max) ? 10'd0 : dec_r + 10'd1;
    end
  end

  // Stage 1: two-tap average at base rate; stage 2: shift accumulator
  logic signed [19:0] s1_r, s1_prev_r;
  logic signed [29:0] acc_r;
  logic signed [19:0] lp_r, hp_state_r;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || cfg_change)
    begin
      s1_r <= '0; s1_prev_r <= '0; acc_r <= '0; lp_r <= '0; hp_state_r <= '0;
    end
    else
    begin
      if (adc_valid_i)
        s1_prev_r <= adc_z_i;
      if (base_tick)
      begin
        s1_r  <= 20'((21'(s1_prev_r) + 21'(adc_z_i)) >>> 1);
        acc_r <= (dec_r == 10'd0) ? 30'(s1_r) : acc_r + 30'(s1_r);
      end
      if (out_tick)
      begin
        lp_r <= (odr_code == 4'd0) ? s1_r : 20'(acc_r >>> odr_code);
        if (hpf_code != 3'd0)
          hp_state_r <= hp_state_r + ((lp_r - hp_state_r) >>> (2 * hpf_code));
      end
    end
  end
  wire signed [19:0] filt = (hpf_code == 3'd0) ? lp_r : lp_r - hp_state_r;

  // Output: each step moves 1/64 of the gap to the filter output, decay to zero in overrange
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      out_r <= '0; sample_o <= '0; sample_valid_o <= 1'b0; interp_tick_o <= 1'b0;
      drive_on_o <= 1'b0; st_enable_o <= 1'b0; st_force_o <= 1'b0;
    end
    else
    begin
      if (ip_tick)
        out_r <= ovr_r ? out_r - (out_r >>> 3)
                       : out_r + ((filt - out_r) >>> 6);
      sample_o       <= out_r;
      sample_valid_o <= ip_tick;
      interp_tick_o  <= ip_tick;
      drive_on_o     <= ~ovr_r;
      st_enable_o    <= self_test_control_r[adf_pkg::ST_ENABLE_BIT];
      st_force_o     <= self_test_control_r[adf_pkg::ST_ENABLE_BIT]
                      & self_test_control_r[adf_pkg::ST_FORCE_BIT];
    end
  end
endmodule : adf_device

// File: logic/adf_host.sv
// Host end: APB-controlled SPI mode 0 master
`timescale 1ns/1ps
module adf_host (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Link
  adf_link_if.host         link
);
  // CTRL: [6:0] reg addr, [8] read, [9] start (self-clearing)
  logic [9:0]  ctrl_r;
  logic [7:0]  wdata_r, rdata_r;
  logic        busy_r;
  logic [1:0]  miso_s_r;
  logic [2:0]  div_r;
  logic [4:0]  edge_cnt_r;
  logic [15:0] sh_r;
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire apb_rd = psel_i & penable_i & ~pwrite_i;
  wire start  = apb_wr & (paddr_i == adf_pkg::HC_CTRL) & pwdata_i[9] & ~busy_r;
  wire known  = (paddr_i == adf_pkg::HC_CTRL) | (paddr_i == adf_pkg::HC_WDATA) |
                (paddr_i == adf_pkg::HC_RDATA) | (paddr_i == adf_pkg::HC_STATUS);
  wire [31:0] rmux = (paddr_i == adf_pkg::HC_CTRL)   ? {22'h0, ctrl_r} :
                     (paddr_i == adf_pkg::HC_WDATA)  ? {24'h0, wdata_r} :
                     (paddr_i == adf_pkg::HC_RDATA)  ? {24'h0, rdata_r} :
                     (paddr_i == adf_pkg::HC_STATUS) ? {31'h0, busy_r} : 32'h0;
  // Divider: 10 MHz SCLK from 100 MHz keeps within range
  wire half = (div_r == 3'(adf_pkg::LINK_DIV_HALF));
  always_ff @(posedge core_clk_i)
  begin
    miso_s_r <= {miso_s_r[0], link.miso};
  end
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= '0; wdata_r <= '0; rdata_r <= '0; busy_r <= 1'b0;
      div_r <= '0; edge_cnt_r <= '0; sh_r <= '0;
      link.sclk <= 1'b0; link.cs_n <= 1'b1; link.mosi <= 1'b0;
      prdata_o <= '0; pready_o <= 1'b0; pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~known;
      prdata_o  <= rmux;
      if (apb_wr && paddr_i == adf_pkg::HC_CTRL && !busy_r)
        ctrl_r <= {1'b0, pwdata_i[8:0]};
      if (apb_wr && paddr_i == adf_pkg::HC_WDATA && !busy_r)
        wdata_r <= pwdata_i[7:0];
      if (start)
      begin
        busy_r     <= 1'b1;
        link.cs_n  <= 1'b0;
        sh_r       <= {pwdata_i[6:0], pwdata_i[8], wdata_r};
        link.mosi  <= pwdata_i[6];
        div_r      <= '0;
        edge_cnt_r <= '0;
      end
      else if (busy_r)
      begin
        div_r <= half ? 3'd0 : div_r + 3'd1;
        if (half)
        begin
          link.sclk <= ~link.sclk;
          if (link.sclk)
          begin
            // Late sampling covers both synchroniser delays on the return path
            rdata_r   <= {rdata_r[6:0], miso_s_r[1]};
            sh_r      <= {sh_r[14:0], 1'b0};
            link.mosi <= sh_r[14];
          end
          // Last fall and deselect together, so sclk idles low
          if (edge_cnt_r == 5'd31)
          begin
            link.cs_n <= 1'b1;
            busy_r    <= 1'b0;
          end
          else
            edge_cnt_r <= edge_cnt_r + 5'd1;
        end
      end
    end
  end
endmodule : adf_host

// File: testbench/adf_link_chk.sv
// Checker: SPI mode 0 wire rules on the host-device link
`timescale 1ns/1ps
module adf_link_chk (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Link
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic       sclk_q_r;
  logic [4:0] rise_cnt_r;
  // Rises counted per frame, cleared while deselected
  always_ff @(posedge core_clk_i)
  begin
    sclk_q_r   <= rst_i ? 1'b0 : sclk;
    rise_cnt_r <= (rst_i || cs_n) ? 5'h00 : rise_cnt_r + 5'(sclk & ~sclk_q_r);
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_idle_low; cs_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low) else $error("sclk high while deselected");
  property p_start_low; $fell(cs_n) |-> !sclk; endproperty
  a_start_low: assert property (p_start_low) else $error("frame opened with sclk high");
  property p_mosi_hold; $rose(sclk) |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at rising sclk");
  property p_miso_hold; $rose(sclk) && miso_oe |-> $stable(miso); endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved at rising sclk");
  property p_high_min; $rose(sclk) |-> sclk[*5]; endproperty
  a_high_min: assert property (p_high_min) else $error("sclk high phase too short");
  property p_low_min; $fell(sclk) |-> !sclk[*5]; endproperty
  a_low_min: assert property (p_low_min) else $error("sclk low phase too short");
  property p_high_max; $rose(sclk) |-> ##[1:500] !sclk; endproperty
  a_high_max: assert property (p_high_max) else $error("sclk high phase too long");
  property p_frame_len; $rose(cs_n) |-> rise_cnt_r == 5'h10; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 16 clocks");
  property p_release; cs_n[*5] |-> !miso_oe; endproperty
  a_release: assert property (p_release) else $error("miso driven while deselected");
endmodule : adf_link_chk

// File: testbench/accel_digital_filter_path_test.sv
// Testbench: host and device joined over the link, driven through APB
`timescale 1ns/1ps
module accel_digital_filter_path_test;
  logic               core_clk_i     = 1'b0;
  logic               rst_i          = 1'b1;
  logic               psel_i         = 1'b0;
  logic               penable_i      = 1'b0;
  logic               pwrite_i       = 1'b0;
  logic [7:0]         paddr_i        = 8'h00;
  logic [31:0]        pwdata_i       = 32'h0;
  logic signed [19:0] adc_z_i        = 20'sh10000;
  logic               adc_valid_i    = 1'b1;
  logic [1:0]         range_i        = 2'h1;
  logic [17:0]        accel_mag_mg_i = 18'h0;
  logic [31:0]        prdata_o;
  logic               pready_o, pslverr_o, drive_on_o, st_enable_o, st_force_o, sample_valid_o, interp_tick_o;
  logic signed [19:0] sample_o;
  int                 fail_count     = 0;
  int                 checks_done    = 0;
  adf_link_if link ();
  adf_host adf_host_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .link(link));
  adf_device adf_device_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link), .adc_z_i(adc_z_i),
    .adc_valid_i(adc_valid_i), .range_i(range_i), .accel_mag_mg_i(accel_mag_mg_i), .drive_on_o(drive_on_o),
    .st_enable_o(st_enable_o), .st_force_o(st_force_o), .sample_o(sample_o), .sample_valid_o(sample_valid_o),
    .interp_tick_o(interp_tick_o));
  adf_link_chk adf_link_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
  always #5 core_clk_i = ~core_clk_i;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic timeout(input string name);
    fail_count++;
    $display("mismatch %s expected answer seen none", name);
    finish_test();
  endtask : timeout
  task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_val
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    cmp_val(name, {31'h0, exp}, {31'h0, got});
  endtask : cmp_bit
  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) timeout("pready");
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, adf_pkg::HC_WDATA, {24'h0, d}, r, e);
    apb(1'b1, adf_pkg::HC_CTRL, {22'h0, 1'b1, rd, 1'b0, a}, r, e);
    n = 0;
    do
    begin
      apb(1'b0, adf_pkg::HC_STATUS, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    if (n >= 100) timeout("busy");
    apb(1'b0, adf_pkg::HC_RDATA, 32'h0, r, e);
    q = r[7:0];
  endtask : xfer
  // Second pass measures edges between two ticks
  task automatic tick_gap(output int n);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(posedge core_clk_i);
        n++;
      end while (interp_tick_o !== 1'b1 && n < 9000);
      if (n >= 9000) timeout("tick");
    end
  endtask : tick_gap
  initial
  begin
    logic [7:0] q;
    logic [31:0] r;
    logic e;
    logic signed [19:0] s0;
    logic signed [19:0] sl;
    logic [7:0] z0, z1, h0, h1;
    int n;
    int g;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    xfer(1'b1, adf_pkg::REG_FILTER_SETTINGS, 8'h00, q);
    cmp_val("filter reset", 32'h0, {24'h0, q});
    for (int c = 0; c < 7; c++)
    begin
      xfer(1'b0, adf_pkg::REG_FILTER_SETTINGS, {1'b0, 3'(c), 4'(c + 4)}, q);
      xfer(1'b1, adf_pkg::REG_FILTER_SETTINGS, 8'h00, q);
      cmp_val("filter_settings", {25'h0, 3'(c), 4'(c + 4)}, {24'h0, q});
    end
    xfer(1'b0, adf_pkg::REG_FILTER_SETTINGS, 8'h0f, q);
    xfer(1'b1, adf_pkg::REG_FILTER_SETTINGS, 8'h00, q);
    cmp_val("rate clamp", 32'h0000000a, {24'h0, q});
    apb(1'b0, 8'h10, 32'h0, r, e);
    cmp_bit("pslverr", 1'b1, e);
    $display("test registers done");
    // Fastest rate last, so the filter refills soonest for the overrange test
    for (int k = 1; k >= 0; k--)
    begin
      xfer(1'b0, adf_pkg::REG_FILTER_SETTINGS, 8'(k), q);
      tick_gap(n);
      g = adf_pkg::BASE_DIV << k;
      cmp_bit("tick period", 1'b1, n >= g - 2 && n <= g + 2);
    end
    $display("test rates done");
    xfer(1'b0, adf_pkg::REG_SELF_TEST_CONTROL, 8'h01, q);
    cmp_bit("st enable", 1'b1, st_enable_o);
    cmp_bit("st force off", 1'b0, st_force_o);
    xfer(1'b1, adf_pkg::REG_ACCEL_Z_HI, 8'h00, z0);
    h0 = sample_o[19:12];
    xfer(1'b0, adf_pkg::REG_SELF_TEST_CONTROL, 8'h03, q);
    cmp_bit("st force", 1'b1, st_force_o);
    xfer(1'b1, adf_pkg::REG_ACCEL_Z_HI, 8'h00, z1);
    h1 = sample_o[19:12];
    cmp_bit("st enable held", 1'b1, st_enable_o);
    cmp_val("st delta", {24'h0, h1 - h0}, {24'h0, z1 - z0});
    xfer(1'b1, adf_pkg::REG_SELF_TEST_CONTROL, 8'h00, q);
    cmp_val("st readback", 32'h3, {24'h0, q});
    xfer(1'b0, adf_pkg::REG_SELF_TEST_CONTROL, 8'h00, q);
    cmp_val("st cleared", 32'h0, {30'h0, st_enable_o, st_force_o});
    $display("test self test done");
    // Below threshold in ranges 2 and 1, then a trip in range 1
    range_i <= 2'h2;
    accel_mag_mg_i <= 18'd55000;
    repeat (100) @(posedge core_clk_i);
    cmp_bit("no trip high range", 1'b1, drive_on_o);
    range_i <= 2'h1;
    accel_mag_mg_i <= 18'd25000;
    repeat (100) @(posedge core_clk_i);
    cmp_bit("no trip low range", 1'b1, drive_on_o);
    // Every rate write empties the filter; wait for the first positive output
    n = 0;
    while (sample_o <= 20'sh0 && n < 60000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 60000) timeout("sample");
    s0 = sample_o;
    sl = sample_o;
    accel_mag_mg_i <= 18'd55000;
    n = 0;
    while (drive_on_o !== 1'b0 && n < 50)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 50) timeout("overrange");
    accel_mag_mg_i <= 18'h0;
    n = 0;
    while (drive_on_o === 1'b0 && n < 60000)
    begin
      sl = sample_o;
      @(posedge core_clk_i);
      n++;
    end
    g = adf_pkg::OVERRANGE_CYCLES;
    cmp_bit("overrange length", 1'b1, n >= g - 3 && n <= g + 3);
    cmp_bit("drift to zero", 1'b1, sl < s0 && sl >= 0);
    $display("test overrange done");
    finish_test();
  end
endmodule : accel_digital_filter_path_test
